// ---- rtl/lcd_cmd_pkg.sv ----
// shared constants, opcodes and types of the lcd host command decoder
package lcd_cmd_pkg;
  localparam int CLK_NS = 100;
  localparam int PROC_NS = 300;
  localparam int PROC_CYC = (PROC_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_NS = 1000;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PROC_LOAD = 4'(PROC_CYC);
  localparam logic [3:0] INIT_LOAD = 4'(INIT_CYC);

  // command opcodes and the bits that must match
  localparam logic [7:0] OP_DISP = 8'hAE;
  localparam logic [7:0] MSK_DISP = 8'hFE;
  localparam logic [7:0] OP_START = 8'h40;
  localparam logic [7:0] MSK_START = 8'hC0;
  localparam logic [7:0] OP_PAGE = 8'hB0;
  localparam logic [7:0] MSK_PAGE = 8'hF0;
  localparam logic [7:0] OP_COLH = 8'h10;
  localparam logic [7:0] OP_COLL = 8'h00;
  localparam logic [7:0] MSK_COL = 8'hF0;
  localparam logic [7:0] OP_ADC = 8'hA0;
  localparam logic [7:0] MSK_ADC = 8'hFE;
  localparam logic [7:0] OP_ALLON = 8'hA4;
  localparam logic [7:0] MSK_ALLON = 8'hFE;
  localparam logic [7:0] OP_RESET = 8'hE2;
  localparam logic [7:0] MSK_RESET = 8'hFF;

  // address space
  localparam logic [7:0] COL_MAX = 8'h83;
  localparam logic [3:0] PAGE_MAX = 4'h8;
  localparam int NUM_PAGES = 9;
  localparam int NUM_COLS = 132;
  localparam int RAM_WORDS = NUM_PAGES * NUM_COLS;

  // reset values
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;

  // status byte fields
  localparam int ST_BUSY = 7;
  localparam int ST_ADC = 6;
  localparam int ST_OFF = 5;
  localparam int ST_RST = 4;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_INIT = 3'b010,
    ST_FETCH = 3'b100
  } core_state_t;
endpackage

// ---- rtl/host_event_if.sv ----
// bus events passed from the host pin front end to the command core
`timescale 1ns/1ns
interface host_event_if;
  logic wr_evt;
  logic is_data;
  logic [7:0] wbyte;
  logic rd_active;
  logic rd_start;
  logic rd_end;
  logic dc_live;
  logic serial_mode;
  modport src(output wr_evt, is_data, wbyte, rd_active, rd_start, rd_end, dc_live, serial_mode);
  modport sink(input wr_evt, is_data, wbyte, rd_active, rd_start, rd_end, dc_live, serial_mode);
endinterface

// ---- rtl/host_bus_frontend.sv ----
// synchronises host pins and turns strobes or serial bits into events
`timescale 1ns/1ns
module host_bus_frontend (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic parallel_select,
  input wire logic strobe_style,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic rd_or_enable,
  input wire logic wr_or_dir,
  input wire logic [7:0] data_in,
  input wire logic serial_clk,
  input wire logic serial_data,
  host_event_if.src ev
);
  logic [15:0] s1_ff;
  logic [15:0] s2_ff;
  logic [15:0] prev_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic wr_evt_ff;
  logic is_data_ff;
  logic [7:0] wbyte_ff;
  logic rd_act_prev_ff;
  logic rd_lvl;
  logic wr_done;
  logic sck_rise;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_ff <= 16'hFFFF;
      s2_ff <= 16'hFFFF;
      prev_ff <= 16'hFFFF;
    end else begin
      s1_ff <= {parallel_select, strobe_style, chip_select_n, data_command_select,
                rd_or_enable, wr_or_dir, serial_clk, serial_data, data_in};
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  // bit 15 parallel, 14 strobe style, 13 cs_n, 12 dc, 11 rd/e, 10 wr/dir, 9 sck, 8 sdi
  always_comb begin
    if (s2_ff[14]) begin
      rd_lvl = !s2_ff[13] && !s2_ff[11];
      wr_done = !prev_ff[13] && !prev_ff[10] && s2_ff[10];
    end else begin
      rd_lvl = !s2_ff[13] && s2_ff[11] && s2_ff[10];
      wr_done = !prev_ff[13] && prev_ff[11] && !s2_ff[11] && !prev_ff[10];
    end
  end

  assign sck_rise = !s2_ff[15] && !s2_ff[13] && s2_ff[9] && !prev_ff[9];

  // serial shift register, cleared while deselected
  always_ff @(posedge mclk) begin
    if (sys_rst || s2_ff[15] || s2_ff[13]) begin
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[6:0], s2_ff[8]};
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_evt_ff <= 1'b0;
      is_data_ff <= 1'b0;
      wbyte_ff <= 8'h00;
    end else if (s2_ff[15] && wr_done) begin
      wr_evt_ff <= 1'b1;
      is_data_ff <= prev_ff[12];
      wbyte_ff <= prev_ff[7:0];
    end else if (sck_rise && bit_cnt_ff == 3'h7) begin
      wr_evt_ff <= 1'b1;
      is_data_ff <= s2_ff[12];
      wbyte_ff <= {shift_ff[6:0], s2_ff[8]};
    end else begin
      wr_evt_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_act_prev_ff <= 1'b0;
    end else begin
      rd_act_prev_ff <= ev.rd_active;
    end
  end

  assign ev.wr_evt = wr_evt_ff;
  assign ev.is_data = is_data_ff;
  assign ev.wbyte = wbyte_ff;
  assign ev.rd_active = s2_ff[15] && rd_lvl;
  assign ev.rd_start = ev.rd_active && !rd_act_prev_ff;
  assign ev.rd_end = !ev.rd_active && rd_act_prev_ff;
  assign ev.dc_live = s2_ff[12];
  assign ev.serial_mode = !s2_ff[15];
endmodule

// ---- rtl/display_ram.sv ----
// display data memory, nine pages of 132 bytes, one-cycle read
`timescale 1ns/1ns
module display_ram (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] page,
  input wire logic [7:0] col,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:lcd_cmd_pkg::RAM_WORDS-1];
  logic [10:0] idx;
  logic in_range;

  assign idx = 11'(page) * 11'(lcd_cmd_pkg::NUM_COLS) + 11'(col);
  assign in_range = (page <= lcd_cmd_pkg::PAGE_MAX) && (col <= lcd_cmd_pkg::COL_MAX);

  always_ff @(posedge mclk) begin
    if (wr_en && in_range) begin
      mem[idx] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rdata <= in_range ? mem[idx] : 8'h00;
    end
  end
endmodule

// ---- rtl/lcd_host_command_decoder.sv ----
// host command decoder of a dot-matrix lcd controller
`timescale 1ns/1ns
// Overview of operation
// - commands decode on internal timing alone; busy rarely needs polling
// - serial bytes arrive most significant bit first and assemble that way
// - command 1010111x turns panel drive on when bit0 set, off otherwise
// - display off while all points forced on enters power saver
// - command 01xxxxxx loads the display start line, 0 to 63
// - command 1011xxxx loads the host page address, 0 to 8
// - loading a page changes only the busy bit of the status byte, for the processing window
// - column pointer loads from two nibble commands, columns 0 to 131
// - column advances after each data access, saturating at 83h, never into page
// - status read returns busy, direction, display off, reset, four zeros
// - direction bit is one for normal mapping, zero for reversed
// - display flag reads zero while drive on, one while off
// - reset bit reads one during hardware or command initialization
// - data write stores byte at page and column, then advances column
// - data read returns byte at page and column, then advances column
// - first data read after column load is a discarded dummy read
// - no display data read path in serial mode
// - command 1010000x selects normal mapping on zero, reversed on one
// - auto increment follows ram column order whatever the mapping
// - hardware reset clears start line, column, page, display off, normal mapping
module lcd_host_command_decoder (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hardware_reset_n,
  input wire logic parallel_select,
  input wire logic strobe_style,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic rd_or_enable,
  input wire logic wr_or_dir,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic serial_clk,
  input wire logic serial_data,
  output logic display_enable,
  output logic power_saver,
  output logic all_points_on,
  output logic segment_reverse,
  output logic [5:0] display_start_line
);
  host_event_if ev ();

  lcd_cmd_pkg::core_state_t st_ff;
  lcd_cmd_pkg::core_state_t nxt_st;
  logic hwr_s1_ff;
  logic hwr_s2_ff;
  logic [3:0] init_cnt_ff;
  logic [3:0] proc_cnt_ff;
  logic [7:0] col_ff;
  logic [3:0] page_ff;
  logic [5:0] start_ff;
  logic disp_on_ff;
  logic seg_rev_ff;
  logic all_on_ff;
  logic saver_ff;
  logic [7:0] read_latch_ff;
  logic [7:0] data_out_ff;
  logic [7:0] ram_rdata;
  logic hw_rst;
  logic in_init;
  logic cmd_wr;
  logic data_wr;
  logic data_rd_end;
  logic soft_rst;
  logic busy;
  logic [7:0] status_byte;
  logic [7:0] cmd;

  function automatic logic op_match(input logic [7:0] b, input logic [7:0] op, input logic [7:0] msk);
    op_match = (b & msk) == op;
  endfunction

  function automatic logic [7:0] col_step(input logic [7:0] c);
    col_step = (c >= lcd_cmd_pkg::COL_MAX) ? lcd_cmd_pkg::COL_MAX : c + 8'h01;
  endfunction

  host_bus_frontend u_front (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .parallel_select(parallel_select),
    .strobe_style(strobe_style),
    .chip_select_n(chip_select_n),
    .data_command_select(data_command_select),
    .rd_or_enable(rd_or_enable),
    .wr_or_dir(wr_or_dir),
    .data_in(data_in),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .ev(ev.src)
  );

  display_ram u_ram (
    .mclk(mclk),
    .wr_en(data_wr),
    .rd_en(data_rd_end),
    .page(page_ff),
    .col(col_ff),
    .wdata(ev.wbyte),
    .rdata(ram_rdata)
  );

  // hardware reset pin synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hwr_s1_ff <= 1'b1;
      hwr_s2_ff <= 1'b1;
    end else begin
      hwr_s1_ff <= hardware_reset_n;
      hwr_s2_ff <= hwr_s1_ff;
    end
  end

  assign hw_rst = !hwr_s2_ff;
  assign in_init = (st_ff == lcd_cmd_pkg::ST_INIT);
  assign cmd = ev.wbyte;
  assign cmd_wr = ev.wr_evt && !ev.is_data && !in_init;
  assign data_wr = ev.wr_evt && ev.is_data && !in_init;
  assign data_rd_end = ev.rd_end && ev.dc_live && !ev.serial_mode && !in_init;
  assign soft_rst = cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_RESET, lcd_cmd_pkg::MSK_RESET);

  // sequencing: run, initialization, ram fetch after a data read
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      lcd_cmd_pkg::ST_RUN: begin
        if (soft_rst) begin
          nxt_st = lcd_cmd_pkg::ST_INIT;
        end else if (data_rd_end) begin
          nxt_st = lcd_cmd_pkg::ST_FETCH;
        end
      end
      lcd_cmd_pkg::ST_INIT: begin
        if (init_cnt_ff == 4'h1) begin
          nxt_st = lcd_cmd_pkg::ST_RUN;
        end
      end
      lcd_cmd_pkg::ST_FETCH: begin
        nxt_st = soft_rst ? lcd_cmd_pkg::ST_INIT : lcd_cmd_pkg::ST_RUN;
      end
      default: begin
        nxt_st = lcd_cmd_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      st_ff <= lcd_cmd_pkg::ST_INIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // initialization timer, held loaded while the reset pin is low
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst || soft_rst) begin
      init_cnt_ff <= lcd_cmd_pkg::INIT_LOAD;
    end else if (in_init && init_cnt_ff != 4'h0) begin
      init_cnt_ff <= init_cnt_ff - 4'h1;
    end
  end

  // short internal processing window after every accepted byte
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      proc_cnt_ff <= 4'h0;
    end else if (cmd_wr || data_wr) begin
      proc_cnt_ff <= lcd_cmd_pkg::PROC_LOAD;
    end else if (proc_cnt_ff != 4'h0) begin
      proc_cnt_ff <= proc_cnt_ff - 4'h1;
    end
  end

  // column pointer
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst || soft_rst) begin
      col_ff <= lcd_cmd_pkg::COL_RST;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_COLH, lcd_cmd_pkg::MSK_COL)) begin
      col_ff <= {cmd[3:0], col_ff[3:0]};
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_COLL, lcd_cmd_pkg::MSK_COL)) begin
      col_ff <= {col_ff[7:4], cmd[3:0]};
    end else if (data_wr || st_ff == lcd_cmd_pkg::ST_FETCH) begin
      col_ff <= col_step(col_ff);
    end
  end

  // page address, never touched by column advance
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst || soft_rst) begin
      page_ff <= lcd_cmd_pkg::PAGE_RST;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_PAGE, lcd_cmd_pkg::MSK_PAGE)) begin
      page_ff <= cmd[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst || soft_rst) begin
      start_ff <= lcd_cmd_pkg::START_RST;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_START, lcd_cmd_pkg::MSK_START)) begin
      start_ff <= cmd[5:0];
    end
  end

  // display drive on/off; the reset command leaves it alone
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      disp_on_ff <= 1'b0;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_DISP, lcd_cmd_pkg::MSK_DISP)) begin
      disp_on_ff <= cmd[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      seg_rev_ff <= 1'b0;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_ADC, lcd_cmd_pkg::MSK_ADC)) begin
      seg_rev_ff <= cmd[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      all_on_ff <= 1'b0;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_ALLON, lcd_cmd_pkg::MSK_ALLON)) begin
      all_on_ff <= cmd[0];
    end
  end

  // power saver: display off with all points on, in either order
  always_ff @(posedge mclk) begin
    if (sys_rst || hw_rst) begin
      saver_ff <= 1'b0;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_DISP, lcd_cmd_pkg::MSK_DISP)) begin
      saver_ff <= !cmd[0] && all_on_ff;
    end else if (cmd_wr && op_match(cmd, lcd_cmd_pkg::OP_ALLON, lcd_cmd_pkg::MSK_ALLON)) begin
      saver_ff <= cmd[0] && !disp_on_ff;
    end
  end

  // read latch: a data read returns the latch, then refills it and advances
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      read_latch_ff <= 8'h00;
    end else if (st_ff == lcd_cmd_pkg::ST_FETCH) begin
      read_latch_ff <= ram_rdata;
    end
  end

  assign busy = in_init || (proc_cnt_ff != 4'h0);

  always_comb begin
    status_byte = 8'h00;
    status_byte[lcd_cmd_pkg::ST_BUSY] = busy;
    status_byte[lcd_cmd_pkg::ST_ADC] = !seg_rev_ff;
    status_byte[lcd_cmd_pkg::ST_OFF] = !disp_on_ff;
    status_byte[lcd_cmd_pkg::ST_RST] = in_init;
  end

  // output byte follows the selected source until a read begins, then freezes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_out_ff <= 8'h00;
    end else if (!ev.rd_active || ev.rd_start) begin
      data_out_ff <= ev.dc_live ? read_latch_ff : status_byte;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = ev.rd_active;
  assign display_enable = disp_on_ff;
  assign power_saver = saver_ff;
  assign all_points_on = all_on_ff;
  assign segment_reverse = seg_rev_ff;
  assign display_start_line = start_ff;
endmodule

// ---- tb/lcd_cmd_chk_sva.sv ----
// port checker for the lcd host command decoder, bound to its top module
`timescale 1ns/1ns
module lcd_cmd_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hardware_reset_n,
  input wire logic parallel_select,
  input wire logic strobe_style,
  input wire logic chip_select_n,
  input wire logic data_command_select,
  input wire logic rd_or_enable,
  input wire logic wr_or_dir,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic display_enable,
  input wire logic power_saver,
  input wire logic all_points_on,
  input wire logic segment_reverse,
  input wire logic [5:0] display_start_line
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_oe_strobe_read: assert property (
    $fell(rd_or_enable) && strobe_style && parallel_select && !chip_select_n && wr_or_dir |-> ##[2:3] data_oe)
    else $error("strobe read gave no output enable");
  a_oe_enable_read: assert property (
    $rose(rd_or_enable) && !strobe_style && parallel_select && !chip_select_n && wr_or_dir |-> ##[2:3] data_oe)
    else $error("enable read gave no output enable");
  a_serial_no_read: assert property ((!parallel_select) [*4] |-> !data_oe)
    else $error("read data driven in serial mode");
  a_read_data_frozen: assert property ($past(data_oe, 2) && $past(data_oe) && data_oe |-> $stable(data_out))
    else $error("read data moved during a read");
  a_status_low_zero: assert property (
    $past(data_oe, 2) && data_oe && !data_command_select |-> data_out[3:0] == 4'h0)
    else $error("status low nibble not zero");
  a_status_dir_bit: assert property (
    $past(data_oe, 2) && data_oe && !data_command_select |-> data_out[6] == !segment_reverse)
    else $error("status direction bit wrong");
  a_status_off_bit: assert property (
    $past(data_oe, 2) && data_oe && !data_command_select |-> data_out[5] == !display_enable)
    else $error("status display bit wrong");
  a_saver_cause: assert property (power_saver |-> all_points_on && !display_enable)
    else $error("power saver without its cause");
  a_hw_reset_state: assert property ((!hardware_reset_n) [*5] |->
    display_start_line == 6'h00 && !display_enable && !segment_reverse && !power_saver)
    else $error("hardware reset left state set");
endmodule

bind lcd_host_command_decoder lcd_cmd_chk chk_u (.mclk, .sys_rst, .hardware_reset_n, .parallel_select,
  .strobe_style, .chip_select_n, .data_command_select, .rd_or_enable, .wr_or_dir, .data_out, .data_oe,
  .display_enable, .power_saver, .all_points_on, .segment_reverse, .display_start_line);

// ---- tb/lcd_host_model.sv ----
// host processor model: strobe, enable and serial bus cycles with fixed spacing
`timescale 1ns/1ns
module lcd_host_model (
  input wire logic mclk,
  input wire logic [7:0] data_out,
  output logic parallel_select,
  output logic strobe_style,
  output logic chip_select_n,
  output logic data_command_select,
  output logic rd_or_enable,
  output logic wr_or_dir,
  output logic [7:0] data_in,
  output logic serial_clk,
  output logic serial_data
);
  initial begin
    parallel_select = 1'b1;
    strobe_style = 1'b1;
    chip_select_n = 1'b1;
    data_command_select = 1'b0;
    rd_or_enable = 1'b1;
    wr_or_dir = 1'b1;
    data_in = 8'h00;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // mode 0 strobe style, 1 enable style, 2 serial; strobes idle while deselected
  task automatic setup(input int mode, input logic dc, input logic rd);
    chip_select_n = 1'b1;
    parallel_select = (mode != 2);
    strobe_style = (mode == 0);
    rd_or_enable = (mode != 1);
    wr_or_dir = (mode == 1) ? rd : 1'b1;
    idle(3);
    data_command_select = dc;
    chip_select_n = 1'b0;
    idle(1);
  endtask

  // released lines show the inverse of their last value; fixed spacing replaces busy polling
  task automatic release_bus();
    chip_select_n = 1'b1;
    data_in = ~data_in;
    serial_data = ~serial_data;
    data_command_select = ~data_command_select;
    idle(4);
  endtask

  task automatic wr(input int mode, input logic dc, input logic [7:0] b);
    setup(mode, dc, 1'b0);
    if (mode == 2) begin
      for (int i = 7; i >= 0; i--) begin
        serial_data = b[i];
        idle(3);
        serial_clk = 1'b1;
        idle(3);
        serial_clk = 1'b0;
      end
    end else begin
      data_in = b;
      if (mode == 0) wr_or_dir = 1'b0;
      else rd_or_enable = 1'b1;
      idle(4);
      if (mode == 0) wr_or_dir = 1'b1;
      else rd_or_enable = 1'b0;
      idle(3);
    end
    release_bus();
  endtask

  task automatic rd(input int mode, input logic dc, output logic [7:0] b);
    setup(mode, dc, 1'b1);
    rd_or_enable = (mode == 1);
    idle(4);
    b = data_out;
    rd_or_enable = (mode != 1);
    idle(3);
    release_bus();
  endtask
endmodule

// ---- tb/lcd_host_command_decoder_tb.sv ----
// self-checking bench of the lcd host command decoder
`timescale 1ns/1ns
module lcd_host_command_decoder_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hardware_reset_n = 1'b1;
  logic parallel_select, strobe_style, chip_select_n, data_command_select, rd_or_enable, wr_or_dir;
  logic serial_clk, serial_data, data_oe, display_enable, power_saver, all_points_on, segment_reverse;
  logic [7:0] data_in, data_out, got;
  logic [5:0] display_start_line, v;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #50 mclk = ~mclk;

  lcd_host_command_decoder dut_u (.mclk, .sys_rst, .hardware_reset_n, .parallel_select, .strobe_style,
    .chip_select_n, .data_command_select, .rd_or_enable, .wr_or_dir, .data_in, .data_out, .data_oe,
    .serial_clk, .serial_data, .display_enable, .power_saver, .all_points_on, .segment_reverse,
    .display_start_line);
  lcd_host_model host_u (.mclk, .data_out, .parallel_select, .strobe_style, .chip_select_n,
    .data_command_select, .rd_or_enable, .wr_or_dir, .data_in, .serial_clk, .serial_data);

  task automatic close_out();
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic logic [7:0] status_exp(input logic rev, input logic on);
    return {1'b0, !rev, !on, 5'h00};
  endfunction

  function automatic int sat_col(input int c);
    return (c > 131) ? 131 : c;
  endfunction

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end

  task automatic st_check(input logic rev, input logic on);
    host_u.rd(0, 1'b0, got);
    chk(got, status_exp(rev, on), "status");
  endtask

  // writes four bytes from col, reloads col, dummy read, reads back through the shadow
  task automatic data_run(input int m, input logic [3:0] pg, input logic [7:0] col);
    logic [7:0] sh [0:131];
    logic [7:0] b;
    host_u.wr(m, 1'b0, {4'hB, pg});
    host_u.wr(m, 1'b0, {4'h1, col[7:4]});
    host_u.wr(m, 1'b0, {4'h0, col[3:0]});
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      sh[sat_col(col + i)] = b;
      host_u.wr(m, 1'b1, b);
    end
    host_u.wr(m, 1'b0, {4'h0, col[3:0]});
    host_u.wr(m, 1'b0, {4'h1, col[7:4]});
    host_u.rd(m, 1'b1, b);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(m, 1'b1, b);
      chk(b, sh[sat_col(col + i)], "ram data");
    end
  endtask

  initial begin
    void'($urandom(32'hD5C39735));
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    host_u.rd(0, 1'b0, got);
    chk(got, 8'hF0, "status in init");
    host_u.idle(10);
    st_check(1'b0, 1'b0);
    for (int m = 0; m < 3; m++) begin
      host_u.wr(m, 1'b0, 8'hAF);
      chk({7'h00, display_enable}, 8'h01, "drive on");
      st_check(1'b0, 1'b1);
      host_u.wr(m, 1'b0, 8'hAE);
      chk({7'h00, display_enable}, 8'h00, "drive off");
    end
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 6'h3F : 6'($urandom);
      host_u.wr(i % 3, 1'b0, {2'b01, v});
      chk({2'b00, display_start_line}, {2'b00, v}, "start line");
    end
    host_u.wr(0, 1'b0, 8'hA1);
    chk({7'h00, segment_reverse}, 8'h01, "reverse map");
    st_check(1'b1, 1'b0);
    data_run(0, 4'($urandom % 9), 8'($urandom % 128));
    host_u.wr(1, 1'b0, 8'hA0);
    chk({7'h00, segment_reverse}, 8'h00, "normal map");
    data_run(1, 4'h8, 8'h82);
    data_run(0, 4'h0, 8'h00);
    host_u.wr(0, 1'b0, 8'hB3);
    st_check(1'b0, 1'b0);
    // all points on while the drive is on must not enter the saver by itself
    host_u.wr(0, 1'b0, 8'hAF);
    host_u.wr(0, 1'b0, 8'hA5);
    chk({6'h00, all_points_on, power_saver}, 8'h02, "all on with drive on");
    host_u.wr(0, 1'b0, 8'hAE);
    chk({7'h00, power_saver}, 8'h01, "saver on");
    host_u.wr(0, 1'b0, 8'hA4);
    chk({6'h00, all_points_on, power_saver}, 8'h00, "saver off");
    host_u.rd(2, 1'b1, got);
    host_u.wr(0, 1'b0, 8'h55);
    host_u.wr(0, 1'b0, 8'hE2);
    chk({2'b00, display_start_line}, 8'h00, "reset command start line");
    // writes are ignored until the initialization window has run out
    host_u.idle(12);
    host_u.wr(0, 1'b0, 8'h55);
    host_u.wr(0, 1'b0, 8'hA1);
    host_u.wr(0, 1'b0, 8'hAF);
    hardware_reset_n = 1'b0;
    host_u.idle(6);
    chk({2'b00, display_start_line}, 8'h00, "reset start line");
    chk({6'h00, display_enable, segment_reverse}, 8'h00, "reset drive and map");
    hardware_reset_n = 1'b1;
    host_u.idle(16);
    st_check(1'b0, 1'b0);
    close_out();
  end
endmodule
